// [logic/octt_top.sv]
// Purpose: Overcurrent trip timer with undercurrent element and register port
// Assumes: Measurements synchronous to clk_i, refreshed by the front end
// Notes: Delays and timer counts are in protection ticks
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/10ps
module octt_top #(
  parameter int TICK_CYCLES = octt_pkg::TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [octt_pkg::AW-1:0] addr_i,
  input wire logic [octt_pkg::DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [octt_pkg::DW-1:0] rdata_o,
  input wire octt_pkg::octt_meas_s meas_i,
  output logic trip_o,
  output logic pickup_o,
  output logic uc_trip_o
);
  import octt_pkg::*;

  // Elaboration check: the divider needs at least two clocks per tick
  if (TICK_CYCLES < 2) begin : g_tick_check
    $error("TICK_CYCLES must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////
  // Settings
  octt_ctrl_s ctrl; // Mode and selection bits
  logic [15:0] pickup; // Pickup current
  logic [31:0] fixed_delay; // Delay of the fixed curve
  logic [15:0] curve_time_multiplier; // 1/64 steps
  logic [31:0] reset_delay_setting; // Definite reset delay
  logic [31:0] user_min_trip_delay; // Zero disables
  logic [15:0] nominal; // Nominal current
  logic [15:0] restraint_voltage_limit; // Full pickup at or above this
  logic [15:0] uc_thresh; // Undercurrent threshold
  logic [31:0] uc_delay; // Undercurrent delay

  // Register writes
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl <= octt_ctrl_s'(CTRL_RESET);
      pickup <= 16'hffff;
      fixed_delay <= 32'h0;
      curve_time_multiplier <= MULT_RESET;
      reset_delay_setting <= 32'h0;
      user_min_trip_delay <= 32'h0;
      nominal <= 16'hffff;
      restraint_voltage_limit <= 16'h0;
      uc_thresh <= 16'h0;
      uc_delay <= 32'h0;
    end else if (wr_i) begin
      case (addr_i)
        REG_CTRL: ctrl <= octt_ctrl_s'(wdata_i[15:0]);
        REG_PICKUP: pickup <= wdata_i[15:0];
        REG_FIXED_DELAY: fixed_delay <= wdata_i;
        REG_MULT: curve_time_multiplier <= wdata_i[15:0];
        REG_RESET_DELAY: reset_delay_setting <= wdata_i;
        REG_MIN_DELAY: user_min_trip_delay <= wdata_i;
        REG_NOMINAL: nominal <= wdata_i[15:0];
        REG_VLIMIT: restraint_voltage_limit <= wdata_i[15:0];
        REG_UC_THRESH: uc_thresh <= wdata_i[15:0];
        REG_UC_DELAY: uc_delay <= wdata_i;
        default: begin
          // Read-only or unmapped: ignored
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Protection tick divider
  logic [31:0] div_cnt; // Cycles within the tick
  logic tick; // One-cycle enable per tick

  // Free-running divider
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_cnt <= 32'h0;
    end else if (div_cnt == 32'(TICK_CYCLES - 1)) begin
      div_cnt <= 32'h0;
    end else begin
      div_cnt <= div_cnt + 32'h1;
    end
  end
  assign tick = (div_cnt == 32'(TICK_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////
  // Measurement selection and effective pickup
  logic [15:0] cur; // Selected current
  logic [15:0] volt; // Selected voltage
  logic [15:0] eff_pickup; // Pickup after restraint
  logic [17:0] volt_x4; // Voltage times steps
  logic [1:0] vr_quarters; // Restraint quarters, less one
  logic dir_ok; // Direction permits pickup
  logic picked; // Overcurrent picked up

  // Current per measuring method
  always_comb begin
    case (ctrl.meas_method)
      MEAS_RMS: cur = meas_i.i_rms;
      MEAS_NEG: cur = meas_i.i_neg;
      default: cur = meas_i.i_fund;
    endcase
  end

  // Voltage per measuring mode
  assign volt = ctrl.volt_mode_pg ? meas_i.v_pg : meas_i.v_pp;
  assign volt_x4 = {volt, 2'b00};

  // Quarter steps of restraint, floor at one quarter
  always_comb begin
    if (volt_x4 >= 18'(3 * restraint_voltage_limit)) begin
      vr_quarters = 2'h2;
    end else if (volt_x4 >= 18'(2 * restraint_voltage_limit)) begin
      vr_quarters = 2'h1;
    end else begin
      vr_quarters = 2'h0;
    end
  end

  // Lower pickup while voltage sags
  always_comb begin
    if (!ctrl.voltage_restraint_enable || volt >= restraint_voltage_limit) begin
      eff_pickup = pickup;
    end else begin
      eff_pickup = 16'((18'(pickup) * (18'(vr_quarters) + 18'h1)) >> 2);
    end
  end

  assign dir_ok = ctrl.non_directional | meas_i.dir_fwd;
  assign picked = ctrl.oc_enable & dir_ok & (cur > eff_pickup);

  ////////////////////////////////////////////////////////////////////////
  // Trip delay computation
  logic is_fixed; // Fixed-delay curve
  logic is_thermal; // Thermal family
  logic [3:0] crv; // Curve index, fixed curve if out of range
  logic [21:0] ceil_a; // Twenty times pickup
  logic [21:0] ceil_b; // Forty times nominal
  logic [21:0] curve_current_ceiling; // Smaller of the two
  logic [21:0] cur_eval; // Current used on the curve
  logic [2:0] bin; // Multiple bin
  logic [23:0] base_delay; // Table delay at unity multiplier
  logic [39:0] scaled_trip; // Delay times multiplier
  logic [39:0] scaled_rst; // Reset tau times multiplier
  logic [31:0] trip_delay; // Effective trip delay
  logic [31:0] inv_reset_delay; // Inverse reset delay

  assign crv = (ctrl.curve > CRV_LAST) ? CRV_FIXED : ctrl.curve;
  assign is_fixed = (crv == CRV_FIXED);
  assign is_thermal = (crv >= CRV_THERM_FIRST);
  assign ceil_a = 22'(CEIL_PICKUP_X) * 22'(eff_pickup);
  assign ceil_b = 22'(CEIL_NOMINAL_X) * 22'(nominal);
  assign curve_current_ceiling = (ceil_a < ceil_b) ? ceil_a : ceil_b;

  // Cap current at the ceiling for all curves but thermal
  always_comb begin
    if (!is_thermal && 22'(cur) > curve_current_ceiling) begin
      cur_eval = curve_current_ceiling;
    end else begin
      cur_eval = 22'(cur);
    end
  end

  // Multiple of pickup as a bin
  always_comb begin
    if (cur_eval >= 22'(BIN_20X) * 22'(eff_pickup)) begin
      bin = 3'h5;
    end else if (cur_eval >= 22'(BIN_10X) * 22'(eff_pickup)) begin
      bin = 3'h4;
    end else if (cur_eval >= 22'(BIN_5X) * 22'(eff_pickup)) begin
      bin = 3'h3;
    end else if (cur_eval >= 22'(BIN_3X) * 22'(eff_pickup)) begin
      bin = 3'h2;
    end else if (cur_eval >= 22'(BIN_2X) * 22'(eff_pickup)) begin
      bin = 3'h1;
    end else begin
      bin = 3'h0;
    end
  end

  assign base_delay = CURVE_TBL[crv][24*bin +: 24];
  assign scaled_trip = 40'(base_delay) * 40'(curve_time_multiplier);
  assign scaled_rst = 40'(RESET_TAU[crv]) * 40'(curve_time_multiplier);

  // Select fixed or curve delay, saturate to 32 bits
  always_comb begin
    if (is_fixed) begin
      trip_delay = fixed_delay;
    end else if (|scaled_trip[39:32+MULT_FRAC]) begin
      trip_delay = 32'hffffffff;
    end else begin
      trip_delay = scaled_trip[32+MULT_FRAC-1:MULT_FRAC];
    end
  end

  assign inv_reset_delay = 32'(scaled_rst >> MULT_FRAC);

  ////////////////////////////////////////////////////////////////////////
  // Trip timing state machine
  octt_state_e state; // Current state
  octt_state_e next_state; // Next state
  logic [31:0] trip_acc; // Accumulated trip timing
  logic [31:0] min_cnt; // User minimum timer
  logic [31:0] rst_cnt; // Reset delay timer
  logic instant_reset; // Reset without delay
  logic [31:0] active_reset_delay; // Reset delay in use
  logic min_ok; // Minimum delay passed
  logic delay_done; // Trip delay passed

  assign instant_reset = is_fixed | (ctrl.reset_mode == RST_INSTANT)
    | (ctrl.reset_mode != RST_DEFINITE && ctrl.reset_mode != RST_INVERSE);
  assign active_reset_delay = (ctrl.reset_mode == RST_INVERSE) ? inv_reset_delay
    : reset_delay_setting;
  assign min_ok = is_fixed | is_thermal | (user_min_trip_delay == 32'h0)
    | (min_cnt >= user_min_trip_delay);
  assign delay_done = (trip_acc >= trip_delay);

  // Next state
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (picked) begin
          next_state = ST_TIMING;
        end
      end
      ST_TIMING, ST_TRIPPED: begin
        if (!picked) begin
          next_state = instant_reset ? ST_IDLE : ST_RESETTING;
        end else if (delay_done && min_ok) begin
          next_state = ST_TRIPPED;
        end
      end
      ST_RESETTING: begin
        if (picked) begin
          next_state = ST_TIMING; // Resume held timing
        end else if (instant_reset || rst_cnt >= active_reset_delay) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Trip accumulator: counts ticks while picked, cleared on reset
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      trip_acc <= 32'h0;
    end else if (next_state == ST_IDLE) begin
      trip_acc <= 32'h0;
    end else if (picked && tick && trip_acc != 32'hffffffff) begin
      trip_acc <= trip_acc + 32'h1;
    end
  end

  // Minimum delay timer, restarted whenever pickup is lost
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      min_cnt <= 32'h0;
    end else if (!picked) begin
      min_cnt <= 32'h0;
    end else if (tick && min_cnt != 32'hffffffff) begin
      min_cnt <= min_cnt + 32'h1;
    end
  end

  // Reset delay timer, runs only while resetting
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_cnt <= 32'h0;
    end else if (state != ST_RESETTING || picked) begin
      rst_cnt <= 32'h0;
    end else if (tick && rst_cnt != 32'hffffffff) begin
      rst_cnt <= rst_cnt + 32'h1;
    end
  end

  // Trip and pickup outputs
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      trip_o <= 1'b0;
      pickup_o <= 1'b0;
    end else begin
      trip_o <= (next_state == ST_TRIPPED);
      pickup_o <= picked;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Undercurrent element
  logic uc_picked; // Undercurrent picked up
  logic [31:0] uc_cnt; // Undercurrent delay timer
  logic [23:0] cur_pct; // Current in percent units
  logic [23:0] drop_pct; // Dropout level in percent units

  assign cur_pct = 24'(cur) * 24'(PCT);
  assign drop_pct = 24'(uc_thresh) * 24'(UC_DROP_PCT);

  // Pickup below threshold, dropout at 103 percent
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      uc_picked <= 1'b0;
    end else if (!ctrl.uc_enable) begin
      uc_picked <= 1'b0;
    end else if (!uc_picked && cur < uc_thresh) begin
      uc_picked <= 1'b1;
    end else if (uc_picked && cur_pct >= drop_pct) begin
      uc_picked <= 1'b0;
    end
  end

  // Delay starts with pickup, trips on expiry
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      uc_cnt <= 32'h0;
      uc_trip_o <= 1'b0;
    end else if (!uc_picked) begin
      uc_cnt <= 32'h0;
      uc_trip_o <= 1'b0;
    end else begin
      if (tick && uc_cnt != 32'hffffffff) begin
        uc_cnt <= uc_cnt + 32'h1;
      end
      uc_trip_o <= (uc_cnt >= uc_delay);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register reads, data one cycle after the strobe
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 32'h0;
    end else if (rd_i) begin
      case (addr_i)
        REG_CTRL: rdata_o <= {16'h0, ctrl};
        REG_PICKUP: rdata_o <= {16'h0, pickup};
        REG_FIXED_DELAY: rdata_o <= fixed_delay;
        REG_MULT: rdata_o <= {16'h0, curve_time_multiplier};
        REG_RESET_DELAY: rdata_o <= reset_delay_setting;
        REG_MIN_DELAY: rdata_o <= user_min_trip_delay;
        REG_NOMINAL: rdata_o <= {16'h0, nominal};
        REG_VLIMIT: rdata_o <= {16'h0, restraint_voltage_limit};
        REG_UC_THRESH: rdata_o <= {16'h0, uc_thresh};
        REG_UC_DELAY: rdata_o <= uc_delay;
        REG_STATUS: rdata_o <= {24'h0, state, uc_trip_o, uc_picked, pickup_o, trip_o};
        REG_TRIP_ACC: rdata_o <= trip_acc;
        default: rdata_o <= 32'h0; // Unmapped reads zero
      endcase
    end else begin
      rdata_o <= 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_trip_needs_delay;
    @(posedge clk_i) disable iff (!resetn_i)
    $rose(trip_o) |-> $past(trip_acc) >= $past(trip_delay);
  endproperty
  a_trip_needs_delay: assert property (p_trip_needs_delay) else $error("Early trip");

  property p_fixed_delay;
    @(posedge clk_i) disable iff (!resetn_i)
    (is_fixed && picked && state == ST_TIMING && trip_acc >= fixed_delay) |=> trip_o;
  endproperty
  a_fixed_delay: assert property (p_fixed_delay) else $error("Fixed delay wrong");

  property p_instant_clear;
    @(posedge clk_i) disable iff (!resetn_i)
    (instant_reset && !picked && state != ST_IDLE) |-> ##[1:2] trip_acc == 32'h0;
  endproperty
  a_instant_clear: assert property (p_instant_clear) else $error("Timing not cleared");

  property p_definite_hold;
    @(posedge clk_i) disable iff (!resetn_i)
    (ctrl.reset_mode == RST_DEFINITE && !is_fixed && state == ST_RESETTING
      && rst_cnt < active_reset_delay && !picked)
      |=> trip_acc == $past(trip_acc);
  endproperty
  a_definite_hold: assert property (p_definite_hold) else $error("Timing not held");

  property p_fixed_no_hold;
    @(posedge clk_i) disable iff (!resetn_i)
    is_fixed |=> state != ST_RESETTING;
  endproperty
  a_fixed_no_hold: assert property (p_fixed_no_hold) else $error("Fixed curve held");

  property p_min_delay;
    @(posedge clk_i) disable iff (!resetn_i)
    ($rose(trip_o) && !is_fixed && !is_thermal && user_min_trip_delay != 32'h0)
      |-> $past(min_cnt) >= user_min_trip_delay;
  endproperty
  a_min_delay: assert property (p_min_delay) else $error("Minimum delay broken");

  property p_ceiling;
    @(posedge clk_i) disable iff (!resetn_i)
    curve_current_ceiling <= ceil_a && curve_current_ceiling <= ceil_b
      && (curve_current_ceiling == ceil_a || curve_current_ceiling == ceil_b);
  endproperty
  a_ceiling: assert property (p_ceiling) else $error("Ceiling wrong");

  property p_cap;
    @(posedge clk_i) disable iff (!resetn_i)
    !is_thermal |-> cur_eval <= curve_current_ceiling;
  endproperty
  a_cap: assert property (p_cap) else $error("Current not capped");

  property p_undirected;
    @(posedge clk_i) disable iff (!resetn_i)
    (ctrl.non_directional && ctrl.oc_enable && cur > eff_pickup) |-> picked;
  endproperty
  a_undirected: assert property (p_undirected) else $error("Direction used");

  property p_uc_drop;
    @(posedge clk_i) disable iff (!resetn_i)
    $fell(uc_picked) && $past(ctrl.uc_enable) |-> $past(cur_pct) >= $past(drop_pct);
  endproperty
  a_uc_drop: assert property (p_uc_drop) else $error("Early dropout");
endmodule

// [shared/octt_pkg.sv]
// Functional notes
// - Trip when delay elapses after pickup exceeded
// - Fixed curve uses delay setting directly
// - Inverse delay from multiplier, curve, multiple
// - Instantaneous reset clears timing within 2 cycles
// - Definite reset holds timing for reset delay
// - Inverse reset delay from curve, not fixed
// - Fixed curve always resets instantly
// - User minimum delay gates trip; zero disables
// - Ceiling is min(20 pickup, 40 nominal)
// - Delay never below curve delay at ceiling
// - Floors apply only to inverse curves
// - Measure fundamental, true RMS or negative sequence
// - Voltage restraint lowers pickup as voltage drops
// - Voltage taken phase-phase or phase-ground
// - Non-directional ignores direction information
// - Fixed, IEC, IEEE, R-shaped and thermal curves
// - Undercurrent drops out at 103% of threshold
// - Undercurrent delay starts below threshold, trips
// - Between pickup and ceiling use curve delay
//
// Purpose: Constants, register map and carriers of the overcurrent trip timer
// Assumes: 100 MHz clock, 1 ms protection tick, delays held in ticks
// Notes: Curve table entries are delays in ticks at a multiplier of one
package octt_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = (TICK_US * 1000) / CLK_PERIOD_NS;
  localparam int DW = 32;
  localparam int AW = 4;
  // Register indices
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_PICKUP = 4'h1;
  localparam logic [3:0] REG_FIXED_DELAY = 4'h2;
  localparam logic [3:0] REG_MULT = 4'h3;
  localparam logic [3:0] REG_RESET_DELAY = 4'h4;
  localparam logic [3:0] REG_MIN_DELAY = 4'h5;
  localparam logic [3:0] REG_NOMINAL = 4'h6;
  localparam logic [3:0] REG_VLIMIT = 4'h7;
  localparam logic [3:0] REG_UC_THRESH = 4'h8;
  localparam logic [3:0] REG_UC_DELAY = 4'h9;
  localparam logic [3:0] REG_STATUS = 4'ha;
  localparam logic [3:0] REG_TRIP_ACC = 4'hb;
  // Control field reset value: non-directional, elements off
  localparam logic [15:0] CTRL_RESET = 16'h0400;
  localparam logic [15:0] MULT_RESET = 16'h0040; // Multiplier 1.0 in 1/64 steps
  localparam int MULT_FRAC = 6;
  // Curve codes
  localparam logic [3:0] CRV_FIXED = 4'h0;
  localparam logic [3:0] CRV_IEC_NORMAL = 4'h1;
  localparam logic [3:0] CRV_IEC_VERY = 4'h2;
  localparam logic [3:0] CRV_IEC_EXTREME = 4'h3;
  localparam logic [3:0] CRV_IEC_LONG = 4'h4;
  localparam logic [3:0] CRV_IEEE_MODERATE = 4'h5;
  localparam logic [3:0] CRV_IEEE_VERY = 4'h6;
  localparam logic [3:0] CRV_IEEE_EXTREME = 4'h7;
  localparam logic [3:0] CRV_R_SHAPED = 4'h8;
  localparam logic [3:0] CRV_THERM_FIRST = 4'h9;
  localparam logic [3:0] CRV_LAST = 4'hc;
  // Reset modes and measuring methods
  localparam logic [1:0] RST_INSTANT = 2'h0;
  localparam logic [1:0] RST_DEFINITE = 2'h1;
  localparam logic [1:0] RST_INVERSE = 2'h2;
  localparam logic [1:0] MEAS_FUND = 2'h0;
  localparam logic [1:0] MEAS_RMS = 2'h1;
  localparam logic [1:0] MEAS_NEG = 2'h2;
  // Ceiling factors, undercurrent dropout ratio in percent
  localparam int CEIL_PICKUP_X = 20;
  localparam int CEIL_NOMINAL_X = 40;
  localparam int UC_DROP_PCT = 103;
  localparam int PCT = 100;
  // Current multiple bin edges and restraint steps in quarters
  localparam int BIN_2X = 2;
  localparam int BIN_3X = 3;
  localparam int BIN_5X = 5;
  localparam int BIN_10X = 10;
  localparam int BIN_20X = 20;
  localparam int VR_STEPS = 4;
  // Trip delay per curve, bins 1.5x,2x,3x,5x,10x,20x (msb first = 20x)
  localparam logic [143:0] CURVE_TBL [13] = '{
    {24'd0, 24'd0, 24'd0, 24'd0, 24'd0, 24'd0},
    {24'd2268, 24'd2971, 24'd4280, 24'd6301, 24'd10029, 24'd17199},
    {24'd711, 24'd1500, 24'd3375, 24'd6750, 24'd13500, 24'd27000},
    {24'd200, 24'd808, 24'd3333, 24'd10000, 24'd26667, 24'd64000},
    {24'd6316, 24'd13333, 24'd30000, 24'd60000, 24'd120000, 24'd240000},
    {24'd948, 24'd1207, 24'd1689, 24'd2432, 24'd3803, 24'd6441},
    {24'd540, 24'd689, 24'd1308, 24'd2942, 24'd7028, 24'd16179},
    {24'd192, 24'd407, 24'd1297, 24'd3647, 24'd9522, 24'd22682},
    {24'd3056, 24'd3171, 24'd3427, 24'd3842, 24'd4525, 24'd5504},
    {24'd15000, 24'd15000, 24'd15000, 24'd15000, 24'd15000, 24'd15000},
    {24'd750, 24'd1500, 24'd3000, 24'd5000, 24'd7500, 24'd10000},
    {24'd38, 24'd150, 24'd600, 24'd1667, 24'd3750, 24'd6667},
    {24'd1, 24'd2, 24'd24, 24'd185, 24'd938, 24'd2963}
  };
  // Inverse reset time constant per curve, in ticks
  localparam logic [23:0] RESET_TAU [13] = '{
    24'd0, 24'd140, 24'd13500, 24'd80000, 24'd120000, 24'd4850,
    24'd21600, 24'd29100, 24'd1000, 24'd45000, 24'd45000, 24'd45000, 24'd45000
  };
  // Measurement carrier from the front end
  typedef struct packed {
    logic [15:0] i_fund;
    logic [15:0] i_rms;
    logic [15:0] i_neg;
    logic [15:0] v_pp;
    logic [15:0] v_pg;
    logic dir_fwd;
  } octt_meas_s;
  // Control register layout
  typedef struct packed {
    logic [2:0] spare;
    logic uc_enable;
    logic oc_enable;
    logic non_directional;
    logic volt_mode_pg;
    logic voltage_restraint_enable;
    logic [1:0] meas_method;
    logic [1:0] reset_mode;
    logic [3:0] curve;
  } octt_ctrl_s;
  // Trip element states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_TIMING = 4'b0010,
    ST_TRIPPED = 4'b0100,
    ST_RESETTING = 4'b1000
  } octt_state_e;
endpackage

// [tb/octt_front_model.sv]
// Purpose: Measurement front end feeding the trip timer
// Assumes: Values refreshed on every clock
// Notes: Each current field differs so the method select shows
`timescale 1ns/10ps
module octt_front_model (
  input wire logic clk_i,
  input wire logic [15:0] cur_i,
  input wire logic [15:0] volt_i,
  input wire logic fwd_i,
  output octt_pkg::octt_meas_s meas_o
);
  import octt_pkg::*;
  ////////////////////////////////////////////////////////////////
  // RMS half, negative sequence quarter, ground voltage half
  always_ff @(posedge clk_i) begin
    meas_o <= '{cur_i, cur_i >> 1, cur_i >> 2, volt_i, volt_i >> 1, fwd_i};
  end
endmodule

// [tb/octt_top_bench.sv]
// Purpose: Self-checking bench of the overcurrent trip timer
// Assumes: Tick shortened to ten clocks
// Notes: Register reads are checked against a queue of expected words
`timescale 1ns/10ps
module octt_top_bench;
  import octt_pkg::*;
  localparam int TK = 10; // Clocks per tick
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic rd_d = 1'b0; // Read answer due
  logic [31:0] rdata_o;
  logic trip_o;
  logic pickup_o;
  logic uc_trip_o;
  logic [15:0] cur = 16'h0; // Commanded current
  logic [15:0] volt = 16'h4b0; // Commanded voltage
  logic fwd = 1'b0; // Commanded direction, high forward
  octt_meas_s meas;
  logic [31:0] exp_q[$]; // Expected read words
  int error_cnt = 0;
  int checks = 0;
  int m;
  ////////////////////////////////////////////////////////////////
  always #5 clk_i = ~clk_i;
  octt_front_model front_u (.clk_i(clk_i), .cur_i(cur), .volt_i(volt),
    .fwd_i(fwd), .meas_o(meas));
  octt_top #(.TICK_CYCLES(TK)) dut_u (.clk_i(clk_i), .resetn_i(resetn_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .meas_i(meas), .trip_o(trip_o), .pickup_o(pickup_o), .uc_trip_o(uc_trip_o));
  ////////////////////////////////////////////////////////////////
  task cmp(input logic [31:0] got, input logic [31:0] want);
    checks++;
    if (got !== want) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task chk(input logic got, input logic want);
    cmp({31'h0, got}, {31'h0, want});
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask
  task setm(input logic [15:0] c, input logic [15:0] v);
    @(posedge clk_i);
    cur <= c;
    volt <= v;
  endtask
  task cy(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Bounded wait for a trip flag
  task wt(input int n, input bit uc);
    for (int k = 0; k < n && (uc ? uc_trip_o : trip_o) !== 1'b1; k++) @(negedge clk_i);
  endtask
  task test_done;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Read monitor: answer stands in the cycle after the strobe
  always @(posedge clk_i) rd_d <= rd_i;
  always @(negedge clk_i) begin
    if (rd_d) cmp(rdata_o, exp_q.pop_front());
  end
  // Watchdog
  initial begin
    #300us;
    error_cnt++;
    test_done;
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(41));
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(REG_CTRL, 32'h400);
    rd(REG_PICKUP, 32'hffff);
    rd(REG_MULT, 32'h40);
    rd(4'hc, 32'h0);
    wr(REG_PICKUP, 32'h64);
    wr(REG_FIXED_DELAY, 32'h3);
    // Fixed curve with definite reset configured
    wr(REG_CTRL, 32'hc10);
    setm(16'hc8, 16'h4b0);
    cy(15);
    chk(pickup_o, 1'b1);
    chk(trip_o, 1'b0);
    wt(40, 1'b0);
    chk(trip_o, 1'b1);
    setm(16'h32, 16'h4b0);
    cy(4);
    chk(trip_o, 1'b0);
    rd(REG_TRIP_ACC, 32'h0);
    // Every measuring method, random current above pickup
    for (m = 0; m < 4; m++) begin
      wr(REG_CTRL, 32'hc00 | (m << 6));
      setm(16'(16'h65 + $urandom % 99), 16'h4b0);
      cy(4);
      chk(pickup_o, m == 0 || m == 3);
      setm(16'h0, 16'h4b0);
    end
    // Direction reverse: only the non-directional mode picks up
    wr(REG_CTRL, 32'h800);
    setm(16'hc8, 16'h4b0);
    cy(4);
    chk(pickup_o, 1'b0);
    @(posedge clk_i) fwd <= 1'b1;
    cy(4);
    chk(pickup_o, 1'b1);
    @(posedge clk_i) fwd <= 1'b0;
    wr(REG_CTRL, 32'hc00);
    cy(4);
    chk(pickup_o, 1'b1);
    // Voltage restraint
    wr(REG_VLIMIT, 32'h3e8);
    wr(REG_CTRL, 32'hd00);
    setm(16'h5a, 16'h4b0);
    cy(4);
    chk(pickup_o, 1'b0);
    wr(REG_CTRL, 32'hf00);
    cy(4);
    chk(pickup_o, 1'b1);
    wr(REG_CTRL, 32'hd00);
    setm(16'h32, 16'h64);
    cy(4);
    chk(pickup_o, 1'b1);
    // Inverse curve above ceiling, user minimum dominates
    setm(16'h0, 16'h4b0);
    wr(REG_CTRL, 32'hc02);
    wr(REG_MIN_DELAY, 32'h3e8);
    setm(16'hfa0, 16'h4b0);
    cy(TK * 990);
    chk(trip_o, 1'b0);
    wt(TK * 20, 1'b0);
    chk(trip_o, 1'b1);
    setm(16'h0, 16'h4b0);
    cy(4);
    rd(REG_TRIP_ACC, 32'h0);
    wr(REG_MIN_DELAY, 32'h0);
    setm(16'hfa0, 16'h4b0);
    cy(TK * 700);
    chk(trip_o, 1'b0);
    wt(TK * 30, 1'b0);
    chk(trip_o, 1'b1);
    // Definite reset holds timing for the reset delay
    wr(REG_RESET_DELAY, 32'ha);
    wr(REG_CTRL, 32'hc12);
    setm(16'h0, 16'h4b0);
    cy(4);
    rd(REG_STATUS, 32'h80);
    cy(TK * 11);
    rd(REG_STATUS, 32'h10);
    rd(REG_TRIP_ACC, 32'h0);
    // Ceiling from forty times nominal moves the curve point
    wr(REG_NOMINAL, 32'h19);
    wr(REG_MULT, 32'h8);
    setm(16'hfa0, 16'h4b0);
    cy(TK * 120);
    chk(trip_o, 1'b0);
    wt(TK * 80, 1'b0);
    chk(trip_o, 1'b1);
    setm(16'h0, 16'h4b0);
    cy(TK * 12);
    // Inverse reset ends well before the definite delay would
    wr(REG_MULT, 32'h1);
    wr(REG_CTRL, 32'hc21);
    setm(16'hfa0, 16'h4b0);
    cy(TK * 2);
    setm(16'h0, 16'h4b0);
    cy(4);
    rd(REG_STATUS, 32'h80);
    cy(TK * 3);
    rd(REG_STATUS, 32'h10);
    // Thermal curve ignores the user minimum and the ceiling
    wr(REG_MIN_DELAY, 32'h3e8);
    wr(REG_CTRL, 32'hc0a);
    setm(16'hfa0, 16'h4b0);
    wt(TK * 20, 1'b0);
    chk(trip_o, 1'b1);
    setm(16'h0, 16'h4b0);
    cy(4);
    chk(trip_o, 1'b0);
    // Undercurrent pickup, delay and dropout ratio
    setm(16'hc8, 16'h4b0);
    wr(REG_UC_THRESH, 32'h64);
    wr(REG_UC_DELAY, 32'h2);
    wr(REG_CTRL, 32'h1000);
    setm(16'h5a, 16'h4b0);
    wt(40, 1'b1);
    chk(uc_trip_o, 1'b1);
    setm(16'h66, 16'h4b0);
    cy(4);
    chk(uc_trip_o, 1'b1);
    setm(16'h67, 16'h4b0);
    cy(4);
    chk(uc_trip_o, 1'b0);
    test_done;
  end
endmodule
